// >>> shared/arc_trip_pkg.sv
// Constants shared by the arc trip routing matrix and its helpers.
// Assumes one core clock domain; switch and sensor pins are asynchronous.
package arc_trip_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int CHAN_COUNT = 15;
  localparam int TRIP_COUNT = 5; // Four trip relays plus the fast output
  localparam int SWITCH_COUNT = 8;
  localparam int SYNC_WIDTH = CHAN_COUNT + SWITCH_COUNT + 2;
  localparam int STATUS_WIDTH = 4;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_MASK = 8'h08;
  localparam logic [7:0] OFS_LED = 8'h0C;
  localparam logic [7:0] OFS_STATE = 8'h10;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_LATCH_CLR = 0; // Write one: release latched outputs
  localparam int CTRL_SOFT_BLOCK = 1; // Software block, ORed with switch
  localparam int ST_TRIP = 0;
  localparam int ST_QUENCH = 1;
  localparam int ST_BLOCKED = 2;
  localparam int ST_LIGHT = 3;
  localparam int SW_SCHEME_LSB = 0;
  localparam int SW_BLOCK = 4;
  localparam int SW_LATCH = 5;
  localparam int SW_LIGHT_ONLY = 7;
  localparam int STATE_SWITCH_LSB = 8;
  localparam int STATE_CURRENT = 16;
  localparam int STATE_SCHEME_OK = 17;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [STATUS_WIDTH-1:0] RST_STATUS = 4'h0;
  localparam logic [STATUS_WIDTH-1:0] RST_MASK = 4'h0;
  localparam logic [CHAN_COUNT-1:0] RST_CHANS = 15'h0000;
  localparam logic [TRIP_COUNT-1:0] RST_TRIPS = 5'h00;

  // ---------------------------------------------------------------
  // Scheme codes and per-scheme channel masks (bit n = channel n+1)
  // ---------------------------------------------------------------
  localparam logic [2:0] SCHEME_ALL = 3'h0;
  localparam logic [2:0] SCHEME_FEEDER = 3'h1;
  localparam logic [2:0] SCHEME_COUPLER = 3'h2;
  localparam logic [CHAN_COUNT-1:0] MASK_NONE = 15'h0000;
  localparam logic [CHAN_COUNT-1:0] MASK_EVERY = 15'h7FFF;
  localparam logic [CHAN_COUNT-1:0] MASK_NO_FIVE = 15'h7FEF;
  localparam logic [CHAN_COUNT-1:0] MASK_NO_ONE_TWO_FIVE = 15'h7FEC;
  localparam logic [CHAN_COUNT-1:0] MASK_ONE_TWO = 15'h0003;
  localparam logic [CHAN_COUNT-1:0] MASK_NOT_ONE_TWO = 15'h7FFC;
  localparam logic [CHAN_COUNT-1:0] MASK_FOURTEEN = 15'h2000;

endpackage : arc_trip_pkg

// >>> shared/route_if.sv
// Carries the synchronised light vector and scheme code to the routing map,
// and the raw per-output demands back to the core.
`timescale 1ns/1ps
interface route_if;
  import arc_trip_pkg::*;
  logic [CHAN_COUNT-1:0] light;
  logic [2:0] scheme;
  logic [3:0] relay_demand;
  logic binary_demand;
  logic fast_demand;
  logic quench_demand;
  logic scheme_valid;

  modport map (
    input light,
    input scheme,
    output relay_demand,
    output binary_demand,
    output fast_demand,
    output quench_demand,
    output scheme_valid
  );
  modport core (
    output light,
    output scheme,
    input relay_demand,
    input binary_demand,
    input fast_demand,
    input quench_demand,
    input scheme_valid
  );
endinterface : route_if

// >>> src/pin_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pins.
// Assumes the bits are independent levels; no bus coherency is implied.
`timescale 1ns/1ps
module pin_sync
  import arc_trip_pkg::*;
#(
  parameter int WIDTH = SYNC_WIDTH
) (
  input wire logic core_clk_i, // Core clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic [WIDTH-1:0] async_i, // Raw pins
  output logic [WIDTH-1:0] sync_o // Synchronised levels
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage is read only by the second stage
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
          meta_reg[b] <= 1'b0;
          sync_reg[b] <= 1'b0;
        end else begin
          meta_reg[b] <= async_i[b];
          sync_reg[b] <= meta_reg[b];
        end
      end
    end
  endgenerate

  assign sync_o = sync_reg;

endmodule : pin_sync

// >>> src/scheme_route_map.sv
// Combinational routing of sensor channels to outputs per logic scheme.
// Assumes light vector is already synchronised; no qualification here.
`timescale 1ns/1ps
module scheme_route_map
  import arc_trip_pkg::*;
(
  route_if.map rt // Light in, demands out
);

  logic [CHAN_COUNT-1:0] m_r1;
  logic [CHAN_COUNT-1:0] m_r2;
  logic [CHAN_COUNT-1:0] m_r3;
  logic [CHAN_COUNT-1:0] m_r4;
  logic [CHAN_COUNT-1:0] m_bo;
  logic [CHAN_COUNT-1:0] m_fast;
  logic [CHAN_COUNT-1:0] m_quench;
  logic valid;

  always_comb begin
    m_r1 = MASK_NONE;
    m_r2 = MASK_NONE;
    m_r3 = MASK_NONE;
    m_r4 = MASK_NONE;
    m_bo = MASK_NONE;
    m_fast = MASK_NONE;
    m_quench = MASK_NONE;
    valid = 1'b0;
    case (rt.scheme)
      SCHEME_ALL: begin
        m_r1 = MASK_EVERY;
        m_r2 = MASK_EVERY;
        m_r3 = MASK_EVERY;
        m_r4 = MASK_EVERY;
        m_bo = MASK_EVERY;
        m_fast = MASK_EVERY;
        m_quench = MASK_NO_FIVE;
        valid = 1'b1;
      end
      SCHEME_FEEDER: begin
        m_r1 = MASK_EVERY;
        m_r2 = MASK_EVERY;
        m_r3 = MASK_EVERY;
        m_r4 = MASK_EVERY;
        m_bo = MASK_EVERY;
        m_fast = MASK_EVERY;
        m_quench = MASK_NO_ONE_TWO_FIVE;
        valid = 1'b1;
      end
      SCHEME_COUPLER: begin
        m_r1 = MASK_EVERY;
        m_r2 = MASK_ONE_TWO;
        m_r3 = MASK_NOT_ONE_TWO;
        m_r4 = MASK_FOURTEEN;
        m_bo = MASK_EVERY;
        m_fast = MASK_EVERY;
        m_quench = MASK_NO_ONE_TWO_FIVE;
        valid = 1'b1;
      end
      default: begin
        valid = 1'b0;
      end
    endcase
  end

  assign rt.relay_demand = {|(rt.light & m_r4), |(rt.light & m_r3),
                            |(rt.light & m_r2), |(rt.light & m_r1)};
  assign rt.binary_demand = |(rt.light & m_bo);
  assign rt.fast_demand = |(rt.light & m_fast);
  assign rt.quench_demand = |(rt.light & m_quench);
  assign rt.scheme_valid = valid;

endmodule : scheme_route_map

// >>> src/arc_trip_scheme_matrix.sv
// Trip routing matrix of an arc flash protection unit, schemes 0 to 2.
// Assumes sensor, current, switch and button pins are asynchronous;
// software reaches the registers over a plain strobe port.
//
// Functional notes
// - Scheme zero: any channel trips everything
// - Scheme zero: channel five never drives quench
// - Blocking suppresses trips, LEDs still light
// - Switch pin eight selects light or light+current
// - Switch off: light and current together
// - Quench output always needs current indication
// - Scheme one: all trip; quench skips one,two,five
// - Scheme two: channels one,two drive relays one,two
// - Scheme two: channel fourteen drives one,three,four
// - Scheme two: others drive one,three; quench except five
// - Scheme from switch pins one to three
// - Latching holds relays, fast output until reset
// - Blocking from switch pin five
`timescale 1ns/1ps
module arc_trip_scheme_matrix
  import arc_trip_pkg::*;
(
  input wire logic core_clk_i, // Core clock, 125 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic [CHAN_COUNT-1:0] sensor_ch_i, // Light pins, ch one at bit 0
  input wire logic current_indication_in_i, // External overcurrent pin
  input wire logic [SWITCH_COUNT-1:0] config_switch_group_i, // Switch pins, pin one at bit 0
  input wire logic reset_button_i, // Push-button, releases latches
  input wire logic [7:0] addr_i, // Register byte address
  input wire logic [31:0] wr_data_i, // Write data
  input wire logic wr_en_i, // Write strobe
  input wire logic rd_en_i, // Read strobe
  output logic [31:0] rd_data_o, // Read data, cycle after strobe
  output logic trip_relay_one_o, // Trip relay one
  output logic trip_relay_two_o, // Trip relay two
  output logic trip_relay_three_o, // Trip relay three
  output logic trip_relay_four_o, // Trip relay four
  output logic binary_out_one_o, // Binary output one
  output logic fast_trip_out_o, // High-speed output
  output logic quench_control_out_o, // Arc-quenching control
  output logic [CHAN_COUNT-1:0] sensor_led_o, // Sticky channel indications
  output logic irq_o // Level interrupt
);

  // ---------------------------------------------------------------
  // Pin synchronisation
  // ---------------------------------------------------------------
  logic [SYNC_WIDTH-1:0] pins_raw;
  logic [SYNC_WIDTH-1:0] pins_sync;
  logic [CHAN_COUNT-1:0] light;
  logic current_seen;
  logic [SWITCH_COUNT-1:0] switches;
  logic button;

  assign pins_raw = {reset_button_i, config_switch_group_i, current_indication_in_i,
                     sensor_ch_i};

  pin_sync #(
    .WIDTH(SYNC_WIDTH)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i(pins_raw),
    .sync_o(pins_sync)
  );

  assign light = pins_sync[CHAN_COUNT-1:0];
  assign current_seen = pins_sync[CHAN_COUNT];
  assign switches = pins_sync[CHAN_COUNT+SWITCH_COUNT:CHAN_COUNT+1];
  assign button = pins_sync[SYNC_WIDTH-1];

  // ---------------------------------------------------------------
  // Configuration decode
  // ---------------------------------------------------------------
  logic [2:0] scheme;
  logic block_sw;
  logic latch_on;
  logic light_only;

  assign scheme = switches[SW_SCHEME_LSB +: 3];
  assign block_sw = switches[SW_BLOCK];
  assign latch_on = switches[SW_LATCH];
  assign light_only = switches[SW_LIGHT_ONLY];

  // ---------------------------------------------------------------
  // Scheme routing
  // ---------------------------------------------------------------
  route_if rt ();

  assign rt.light = light;
  assign rt.scheme = scheme;

  scheme_route_map u_map (
    .rt(rt.map)
  );

  // ---------------------------------------------------------------
  // Button edge, one pulse per press
  // ---------------------------------------------------------------
  logic button_reg;
  logic button_next;
  logic button_rise;

  always_comb begin
    button_next = button;
    button_rise = button & ~button_reg;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      button_reg <= 1'b0;
    end else begin
      button_reg <= button_next;
    end
  end

  // ---------------------------------------------------------------
  // Register writes decoded
  // ---------------------------------------------------------------
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic wr_led;
  logic latch_clr;
  logic block_all;
  logic soft_block_reg;
  logic soft_block_next;

  always_comb begin
    wr_ctrl = wr_en_i && (addr_i == OFS_CTRL);
    wr_status = wr_en_i && (addr_i == OFS_STATUS);
    wr_mask = wr_en_i && (addr_i == OFS_MASK);
    wr_led = wr_en_i && (addr_i == OFS_LED);
    // Clear is a pulse; the register bit is not stored
    latch_clr = (wr_ctrl & wr_data_i[CTRL_LATCH_CLR]) | button_rise;
    soft_block_next = wr_ctrl ? wr_data_i[CTRL_SOFT_BLOCK] : soft_block_reg;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      soft_block_reg <= 1'b0;
    end else begin
      soft_block_reg <= soft_block_next;
    end
  end

  assign block_all = block_sw | soft_block_reg;

  // ---------------------------------------------------------------
  // Trip qualification and latching
  // ---------------------------------------------------------------
  // Index 0..3 are the relays, index 4 the fast output
  logic crit_ok;
  logic [TRIP_COUNT-1:0] trip_act;
  logic [TRIP_COUNT-1:0] hold_reg;
  logic [TRIP_COUNT-1:0] hold_next;
  logic [TRIP_COUNT-1:0] trip_out_reg;
  logic [TRIP_COUNT-1:0] trip_out_next;
  logic bo_reg;
  logic bo_next;
  logic quench_reg;
  logic quench_next;

  always_comb begin
    // Switch off means light and current must coincide
    crit_ok = light_only | current_seen;
    trip_act = RST_TRIPS;
    if (rt.scheme_valid && !block_all) begin
      trip_act = {rt.fast_demand, rt.relay_demand} & {TRIP_COUNT{crit_ok}};
    end
    // Latched hold: a new trip in the clear cycle survives the clear
    hold_next = RST_TRIPS;
    if (latch_on) begin
      hold_next = (hold_reg & ~{TRIP_COUNT{latch_clr}}) | trip_act;
    end
    // Blocking also masks held outputs while it is on
    trip_out_next = (trip_act | hold_reg) & ~{TRIP_COUNT{block_all}};
    if (!rt.scheme_valid) begin
      trip_out_next = RST_TRIPS;
    end
    // Binary output follows light only
    bo_next = rt.binary_demand & rt.scheme_valid & ~block_all;
    // Quench needs current even in light-only mode
    quench_next = rt.quench_demand & current_seen & rt.scheme_valid
                  & ~block_all;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hold_reg <= RST_TRIPS;
      trip_out_reg <= RST_TRIPS;
      bo_reg <= 1'b0;
      quench_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      trip_out_reg <= trip_out_next;
      bo_reg <= bo_next;
      quench_reg <= quench_next;
    end
  end

  assign trip_relay_one_o = trip_out_reg[0];
  assign trip_relay_two_o = trip_out_reg[1];
  assign trip_relay_three_o = trip_out_reg[2];
  assign trip_relay_four_o = trip_out_reg[3];
  assign fast_trip_out_o = trip_out_reg[4];
  assign binary_out_one_o = bo_reg;
  assign quench_control_out_o = quench_reg;

  // ---------------------------------------------------------------
  // Channel indications
  // ---------------------------------------------------------------
  // Indications ignore blocking, so a blocked arc is still shown
  logic [CHAN_COUNT-1:0] led_reg;
  logic [CHAN_COUNT-1:0] led_next;
  logic [CHAN_COUNT-1:0] led_clr;

  always_comb begin
    led_clr = RST_CHANS;
    if (wr_led) begin
      led_clr = wr_data_i[CHAN_COUNT-1:0];
    end
    if (button_rise) begin
      led_clr = MASK_EVERY;
    end
    led_next = (led_reg & ~led_clr) | light;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      led_reg <= RST_CHANS;
    end else begin
      led_reg <= led_next;
    end
  end

  assign sensor_led_o = led_reg;

  // ---------------------------------------------------------------
  // Event status and interrupt
  // ---------------------------------------------------------------
  logic [STATUS_WIDTH-1:0] status_reg;
  logic [STATUS_WIDTH-1:0] status_next;
  logic [STATUS_WIDTH-1:0] mask_reg;
  logic [STATUS_WIDTH-1:0] mask_next;
  logic [STATUS_WIDTH-1:0] events;
  logic [STATUS_WIDTH-1:0] status_clr;
  logic irq_reg;
  logic irq_next;

  always_comb begin
    events = RST_STATUS;
    events[ST_TRIP] = |trip_act;
    events[ST_QUENCH] = quench_next;
    events[ST_BLOCKED] = block_all & (|light);
    events[ST_LIGHT] = |light;
    status_clr = RST_STATUS;
    if (wr_status) begin
      status_clr = wr_data_i[STATUS_WIDTH-1:0];
    end
    // Set beats clear in the same cycle
    status_next = (status_reg & ~status_clr) | events;
    mask_next = wr_mask ? wr_data_i[STATUS_WIDTH-1:0] : mask_reg;
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      status_reg <= RST_STATUS;
      mask_reg <= RST_MASK;
      irq_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
    end
  end

  assign irq_o = irq_reg;

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic [31:0] state_word;

  always_comb begin
    state_word = RST_WORD;
    state_word[TRIP_COUNT-1:0] = trip_out_reg;
    state_word[TRIP_COUNT] = bo_reg;
    state_word[TRIP_COUNT+1] = quench_reg;
    state_word[STATE_SWITCH_LSB +: SWITCH_COUNT] = switches;
    state_word[STATE_CURRENT] = current_seen;
    state_word[STATE_SCHEME_OK] = rt.scheme_valid;
    rd_next = RST_WORD;
    if (rd_en_i) begin
      case (addr_i)
        OFS_CTRL: begin
          rd_next[CTRL_SOFT_BLOCK] = soft_block_reg;
        end
        OFS_STATUS: begin
          rd_next[STATUS_WIDTH-1:0] = status_reg;
        end
        OFS_MASK: begin
          rd_next[STATUS_WIDTH-1:0] = mask_reg;
        end
        OFS_LED: begin
          rd_next[CHAN_COUNT-1:0] = led_reg;
        end
        OFS_STATE: begin
          rd_next = state_word;
        end
        default: begin
          rd_next = RST_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rd_reg <= RST_WORD;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign rd_data_o = rd_reg;

endmodule : arc_trip_scheme_matrix

// >>> verification/field_sensor_model.sv
// Behavioural model of the light sensors and the external current relay.
// Assumes the bench commands levels; the pins are async to the core clock.
`timescale 1ns/1ps
module field_sensor_model
  import arc_trip_pkg::*;
(
  input wire logic [CHAN_COUNT-1:0] light_cmd_i, // Requested light per channel
  input wire logic current_cmd_i, // Requested overcurrent state
  output logic [CHAN_COUNT-1:0] sensor_ch_o, // Sensor pins
  output logic current_o // Current relay pin
);
  // Levels pass straight through; a real sensor holds light as a level too
  assign sensor_ch_o = light_cmd_i;
  assign current_o = current_cmd_i;
endmodule : field_sensor_model

// >>> verification/arc_trip_scheme_matrix_monitor.sv
// Port-level checker for the arc trip routing matrix.
// Assumes one clock; pins reach outputs after three edges.
`timescale 1ns/1ps
module arc_trip_scheme_matrix_monitor
  import arc_trip_pkg::*;
(
  input wire logic core_clk_i, // Core clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [CHAN_COUNT-1:0] sensor_ch_i, // Light pins
  input wire logic current_indication_in_i, // Current pin
  input wire logic [SWITCH_COUNT-1:0] config_switch_group_i, // Switches
  input wire logic reset_button_i, // Button
  input wire logic [7:0] addr_i, // Address
  input wire logic [31:0] wr_data_i, // Write data
  input wire logic wr_en_i, // Write strobe
  input wire logic rd_en_i, // Read strobe
  input wire logic [31:0] rd_data_o, // Read data
  input wire logic trip_relay_one_o, // Relay one
  input wire logic trip_relay_two_o, // Relay two
  input wire logic trip_relay_three_o, // Relay three
  input wire logic trip_relay_four_o, // Relay four
  input wire logic binary_out_one_o, // Binary out
  input wire logic fast_trip_out_o, // Fast out
  input wire logic quench_control_out_o, // Quench out
  input wire logic [CHAN_COUNT-1:0] sensor_led_o, // LEDs
  input wire logic irq_o // Interrupt
);
  logic soft_reg;
  logic [2:0] up_reg;
  logic ready;
  logic plain;
  logic [6:0] outs;
  logic [2:0] scheme;
  // Soft block shadow, so positive checks skip blocked stretches
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      soft_reg <= 1'b0;
      up_reg <= 3'h0;
    end else begin
      if (wr_en_i && addr_i == OFS_CTRL) begin
        soft_reg <= wr_data_i[CTRL_SOFT_BLOCK];
      end
      if (up_reg != 3'h4) begin
        up_reg <= up_reg + 3'h1;
      end
    end
  end
  assign ready = (up_reg == 3'h4) && !soft_reg;
  assign scheme = config_switch_group_i[2:0];
  assign plain = !config_switch_group_i[SW_BLOCK] && !config_switch_group_i[SW_LATCH];
  assign outs = {quench_control_out_o, fast_trip_out_o, binary_out_one_o, trip_relay_four_o,
                 trip_relay_three_o, trip_relay_two_o, trip_relay_one_o};
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  chk_block_quiet: assert property (
    $past(config_switch_group_i[SW_BLOCK], 3) |-> outs == 7'h00)
    else $error("outputs active while blocked");
  chk_bad_scheme: assert property ($past(scheme, 3) > 3'h2 |-> outs == 7'h00)
    else $error("outputs active for unsupported scheme");
  chk_quench_current: assert property (
    quench_control_out_o |-> $past(current_indication_in_i, 3))
    else $error("quench without current");
  chk_trip_criterion: assert property (
    $rose(trip_relay_one_o) && !$past(config_switch_group_i[SW_LATCH], 3)
    |-> $past(sensor_ch_i != 15'h0000, 3) && ($past(config_switch_group_i[SW_LIGHT_ONLY], 3)
    || $past(current_indication_in_i, 3)))
    else $error("relay rose without qualified light");
  chk_all_trip: assert property (ready && !$past(soft_reg) && $past(plain && scheme == 3'h0
    && config_switch_group_i[SW_LIGHT_ONLY] && sensor_ch_i != 15'h0000, 3) |-> outs[5:0] == 6'h3F)
    else $error("scheme zero light did not trip all");
  chk_five_quench: assert property ($past(scheme == 3'h0 && sensor_ch_i == 15'h0010, 3)
    |-> !quench_control_out_o)
    else $error("channel five drove quench");
  chk_feeder_quench: assert property (
    $past(scheme == 3'h1 && (sensor_ch_i & 15'h7FEC) == 15'h0000, 3) |-> !quench_control_out_o)
    else $error("scheme one quench from excluded channel");
  chk_coupler_map: assert property (
    ready && !$past(soft_reg) && $past(plain && scheme == 3'h2 && sensor_ch_i == 15'h2000
    && current_indication_in_i, 3) |-> outs == 7'h7D)
    else $error("scheme two channel fourteen map wrong");
  chk_relay_two: assert property (
    !$past(config_switch_group_i[SW_LATCH], 3) && $past(scheme == 3'h2
    && sensor_ch_i[1:0] == 2'b00, 3) |-> !trip_relay_two_o)
    else $error("scheme two relay two without channel one or two");
  cov_trip: cover property ($rose(trip_relay_one_o));
  cov_quench: cover property ($rose(quench_control_out_o));
  cov_irq: cover property ($rose(irq_o));
endmodule : arc_trip_scheme_matrix_monitor

bind arc_trip_scheme_matrix arc_trip_scheme_matrix_monitor arc_trip_scheme_matrix_monitor_i (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .sensor_ch_i(sensor_ch_i),
  .current_indication_in_i(current_indication_in_i), .config_switch_group_i(config_switch_group_i),
  .reset_button_i(reset_button_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .trip_relay_one_o(trip_relay_one_o),
  .trip_relay_two_o(trip_relay_two_o), .trip_relay_three_o(trip_relay_three_o),
  .trip_relay_four_o(trip_relay_four_o), .binary_out_one_o(binary_out_one_o),
  .fast_trip_out_o(fast_trip_out_o), .quench_control_out_o(quench_control_out_o),
  .sensor_led_o(sensor_led_o), .irq_o(irq_o));

// >>> verification/arc_trip_scheme_matrix_bench.sv
// Self-checking bench for the arc trip routing matrix.
// Assumes the field model drives the sensor and current pins; registers via the strobe port.
`timescale 1ns/1ps
module arc_trip_scheme_matrix_bench;
  import arc_trip_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [CHAN_COUNT-1:0] light_cmd = 15'h0000;
  logic cur_cmd = 1'b0;
  logic [SWITCH_COUNT-1:0] sw = 8'h00;
  logic button = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  wire [CHAN_COUNT-1:0] sens;
  wire cur;
  wire [31:0] rd_data;
  wire [CHAN_COUNT-1:0] leds;
  wire [6:0] outs; // Quench, fast, binary, relays four..one
  wire irq;
  int n_errors = 0;
  int check_count = 0;
  logic [31:0] rd;
  // Rows: light, current, switches
  logic [23:0] tbl [15] = '{
    {15'h0001, 1'b1, 8'h80}, {15'h0010, 1'b1, 8'h80}, {15'h0004, 1'b0, 8'h80},
    {15'h0004, 1'b0, 8'h00}, {15'h0004, 1'b1, 8'h00}, {15'h0002, 1'b1, 8'h81},
    {15'h0008, 1'b1, 8'h81}, {15'h0001, 1'b1, 8'h82}, {15'h2000, 1'b1, 8'h82},
    {15'h4004, 1'b1, 8'h82}, {15'h0010, 1'b1, 8'h82}, {15'h0040, 1'b1, 8'h90},
    {15'h0001, 1'b1, 8'h83}, {15'h0001, 1'b1, 8'h87}, {15'h0000, 1'b1, 8'h80}};

  always #4 core_clk_i = ~core_clk_i;

  field_sensor_model field_sensor_model_i (.light_cmd_i(light_cmd), .current_cmd_i(cur_cmd),
    .sensor_ch_o(sens), .current_o(cur));
  arc_trip_scheme_matrix arc_trip_scheme_matrix_i (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .sensor_ch_i(sens), .current_indication_in_i(cur), .config_switch_group_i(sw),
    .reset_button_i(button), .addr_i(addr), .wr_data_i(wdata), .wr_en_i(wr_en),
    .rd_en_i(rd_en), .rd_data_o(rd_data), .trip_relay_one_o(outs[0]),
    .trip_relay_two_o(outs[1]), .trip_relay_three_o(outs[2]), .trip_relay_four_o(outs[3]),
    .binary_out_one_o(outs[4]), .fast_trip_out_o(outs[5]), .quench_control_out_o(outs[6]),
    .sensor_led_o(leds), .irq_o(irq));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cycles
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk_i);
    wr_en <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk_i);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : bus_rd
  task automatic chk_word(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : chk_word
  task automatic chk_outs(input logic [6:0] exp);
    check_count++;
    if (outs !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, outs);
    end
  endtask : chk_outs
  task automatic set_pins(input logic [14:0] s, input logic c, input logic [7:0] w);
    @(posedge core_clk_i);
    light_cmd <= s;
    cur_cmd <= c;
    sw <= w;
    cycles(5);
  endtask : set_pins
  task automatic summarize;
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  function automatic logic [6:0] exp_outs(input logic [14:0] s, input logic c,
                                          input logic [7:0] w);
    logic any;
    logic go;
    logic [3:0] rel;
    logic q;
    any = |s;
    go = any && (w[7] || c);
    rel = {4{go}};
    q = c && |(s & 15'h7FEF);
    if (w[2:0] != 3'h0) q = c && |(s & 15'h7FEC);
    if (w[2:0] == 3'h2) rel = {s[13], |s[14:2], |s[1:0], any} & {4{go}};
    if (w[2:0] > 3'h2 || w[4]) return 7'h00;
    return {q, go, any, rel};
  endfunction : exp_outs

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'b0;
    bus_rd(OFS_STATUS, rd);
    chk_word(32'h0000_0000, rd);
    bus_rd(OFS_MASK, rd);
    chk_word(32'h0000_0000, rd);
    foreach (tbl[i]) begin
      set_pins(tbl[i][23:9], tbl[i][8], tbl[i][7:0]);
      chk_outs(exp_outs(tbl[i][23:9], tbl[i][8], tbl[i][7:0]));
    end
    chk_word(32'h0000_605F, {17'h0, leds});
    bus_rd(OFS_STATUS, rd);
    chk_word(32'h0000_000F, rd);
    bus_wr(OFS_MASK, 32'h0000_0001);
    cycles(2);
    chk_word(32'h0000_0001, {31'h0, irq});
    bus_wr(OFS_STATUS, 32'h0000_000F);
    cycles(2);
    chk_word(32'h0000_0000, {31'h0, irq});
    bus_wr(OFS_LED, 32'h0000_7FFF);
    bus_rd(OFS_LED, rd);
    chk_word(32'h0000_0000, rd);
    bus_rd(8'h40, rd);
    chk_word(32'h0000_0000, rd);
    bus_wr(OFS_CTRL, 32'h0000_0002);
    set_pins(15'h0001, 1'b1, 8'h80);
    chk_outs(7'h00);
    bus_wr(OFS_CTRL, 32'h0000_0000);
    cycles(2);
    chk_outs(7'h7F);
    set_pins(15'h0001, 1'b1, 8'hA0);
    set_pins(15'h0000, 1'b0, 8'hA0);
    chk_outs(7'h2F);
    bus_wr(OFS_CTRL, 32'h0000_0001);
    cycles(2);
    chk_outs(7'h00);
    set_pins(15'h0001, 1'b1, 8'hA0);
    set_pins(15'h0000, 1'b0, 8'hA0);
    chk_outs(7'h2F);
    @(posedge core_clk_i);
    button <= 1'b1;
    cycles(5);
    @(posedge core_clk_i);
    button <= 1'b0;
    cycles(1);
    chk_outs(7'h00);
    chk_word(32'h0000_0000, {17'h0, leds});
    summarize();
  end
endmodule : arc_trip_scheme_matrix_bench
